// ### rtl/serial_port_pkg.sv
package serial_port_pkg;

  // ==========================================================
  // Timing and layout constants
  // ==========================================================
  localparam int BASE_OVERSAMPLE = 16;
  localparam logic [3:0] SAMPLE_TICK = 4'h7;
  localparam logic [3:0] LAST_TICK = 4'(BASE_OVERSAMPLE - 1);
  localparam int BASE_DIV_DEFAULT = 54;
  localparam int DIV_WIDTH = 16;
  localparam int DATA_WIDTH = 8;
  localparam int FIFO_DEPTH_DEFAULT = 8;
  localparam logic [7:0] PORT_A_CH3_MASK = 8'h68;
  localparam logic [2:0] LAST_BIT_SEVEN = 3'h6;
  localparam logic [2:0] LAST_BIT_EIGHT = 3'h7;
  localparam logic TX_EMPTY_RESET = 1'b1;
  localparam logic TX_END_RESET = 1'b1;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_type;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_type;

  typedef struct packed {
    logic sync;
    logic sevenBit;
    logic parityEnable;
    logic parityOdd;
    logic twoStop;
  } frame_cfg_type;

  typedef struct packed {
    logic parity;
    logic framing;
    logic overrun;
  } err_flags_type;

  typedef struct packed {
    logic [DIV_WIDTH-1:0] divCnt;
    tx_state_type txState;
    logic [3:0] txTick;
    logic [2:0] txBit;
    logic [7:0] txShift;
    logic txParity;
    logic txStop2;
    logic txLine;
    logic [7:0] txHolding;
    logic txEmpty;
    logic txEnd;
    rx_state_type rxState;
    logic [3:0] rxTick;
    logic [2:0] rxBit;
    logic [7:0] rxShift;
    logic rxParity;
    logic [7:0] rxHolding;
    logic rxFull;
    err_flags_type err;
  } core_state_type;

endpackage

// ### rtl/rx_byte_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module rx_byte_fifo #(
  parameter int WIDTH = serial_port_pkg::DATA_WIDTH,
  parameter int DEPTH = serial_port_pkg::FIFO_DEPTH_DEFAULT
) (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Synchronous reset
  input wire logic inValid, // Word offered
  output logic inReady, // Room for a word
  input wire logic [WIDTH-1:0] inData, // Word in
  output logic outValid, // Word available
  input wire logic outReady, // Consumer takes word
  output logic [WIDTH-1:0] outData // Oldest word
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] rdPtr;
    logic [PW-1:0] wrPtr;
    logic [PW:0] count;
  } fifo_state_type;

  fifo_state_type s;
  fifo_state_type next_s;

  // ==========================================================
  // Flags
  // ==========================================================
  // Full and empty come straight from the count, so they never lie
  assign inReady = (s.count != (PW+1)'(DEPTH));
  assign outValid = (s.count != '0);
  assign outData = s.mem[s.rdPtr];

  // Pointer wrap is by index compare so any depth of two or more works
  always_comb
  begin
    logic push;
    logic pop;
    push = 1'b0;
    pop = 1'b0;
    next_s = s;
    push = inValid && inReady;
    pop = outValid && outReady;
    if (push)
    begin
      next_s.mem[s.wrPtr] = inData;
      next_s.wrPtr = (s.wrPtr == PW'(DEPTH - 1)) ? '0 : s.wrPtr + 1'b1;
    end
    if (pop)
      next_s.rdPtr = (s.rdPtr == PW'(DEPTH - 1)) ? '0 : s.rdPtr + 1'b1;
    if (push && !pop)
      next_s.count = s.count + 1'b1;
    else if (pop && !push)
      next_s.count = s.count - 1'b1;
  end

  // Register the state
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      s <= '0;
    else
      s <= next_s;
  end

endmodule
`default_nettype wire

// ### rtl/serial_port_errors_and_break.sv
`timescale 1ns/100ps
`default_nettype none
module serial_port_errors_and_break #(
  parameter logic [15:0] CLK_PER_BASE = 16'(serial_port_pkg::BASE_DIV_DEFAULT),
  parameter int FIFO_DEPTH = serial_port_pkg::FIFO_DEPTH_DEFAULT
) (
  input wire logic clk_sys, // System clock, 100 MHz
  input wire logic reset, // Synchronous, active high
  input wire serial_port_pkg::frame_cfg_type frameCfg, // Mode and format
  input wire logic txEnable, // tx_enable_bit
  input wire logic rxEnable, // rx_enable_bit
  input wire logic portDataBit, // port_data_bit of transmit pin
  input wire logic portDirBit, // Port direction of transmit pin
  input wire logic [7:0] portACtrl, // port_a_control_reg
  input wire logic txWrite, // Write strobe for holding register
  input wire logic [7:0] txData, // Byte written
  input wire serial_port_pkg::err_flags_type errClear, // Write-0 pulses per flag
  input wire logic rxPin, // Receive line
  output logic txPinOut, // Transmit pin level
  output logic txPinOe, // Transmit pin driven
  output logic sclkOut, // Serial clock, synchronous mode
  output logic ch3PinsOn, // Channel pins usable
  output logic txEmptyFlag, // tx_empty_flag
  output logic txEndFlag, // Set when enabled and idle with holding empty, cleared only at load
  output logic rxFullFlag, // rx_full_flag
  output serial_port_pkg::err_flags_type errFlags, // overrun/framing/parity flags
  output logic rxErrorIrq, // rx_error_irq
  output logic [7:0] rxHoldingData, // rx_holding_reg
  output logic rxValid, // Received byte available
  input wire logic rxReady, // Consumer takes byte
  output logic [7:0] rxData // Received byte
);

  serial_port_pkg::core_state_type s;
  serial_port_pkg::core_state_type next_s;
  logic fifoInReady;

  // Even parity over the active data bits, odd adds one inversion
  function automatic logic parityOf(input logic [7:0] d, input logic seven, input logic odd);
    logic [7:0] m;
    m = seven ? {1'b0, d[6:0]} : d;
    return (^m) ^ odd;
  endfunction

  // ==========================================================
  // Pin muxing and status outputs
  // ==========================================================
  // All three control bits must be set, else pins stay released
  assign ch3PinsOn = ((portACtrl & serial_port_pkg::PORT_A_CH3_MASK) == serial_port_pkg::PORT_A_CH3_MASK);
  assign txPinOut = txEnable ? s.txLine : portDataBit;
  assign txPinOe = ch3PinsOn && (txEnable || portDirBit);
  assign sclkOut = (frameCfg.sync && s.txState == serial_port_pkg::TX_DATA) ? s.txTick[3] : 1'b1;
  assign txEmptyFlag = s.txEmpty;
  assign txEndFlag = s.txEnd;
  assign rxFullFlag = s.rxFull;
  assign errFlags = s.err;
  assign rxErrorIrq = s.err.overrun || s.err.framing || s.err.parity;
  assign rxHoldingData = s.rxHolding;

  // ==========================================================
  // Next-state logic
  // ==========================================================
  // One pass covers divider, transmitter, receiver and flags; ordering
  // inside the pass sets which update wins in a shared cycle
  always_comb
  begin
    logic tick;
    logic rxIn;
    logic halt;
    logic anyErr;
    logic [2:0] lastBit;
    logic bitEnd;
    logic sample;
    logic done;
    logic ferr;
    logic perr;
    logic [7:0] word;
    tick = 1'b0;
    rxIn = 1'b1;
    halt = 1'b0;
    anyErr = 1'b0;
    lastBit = serial_port_pkg::LAST_BIT_EIGHT;
    bitEnd = 1'b0;
    sample = 1'b0;
    done = 1'b0;
    ferr = 1'b0;
    perr = 1'b0;
    word = '0;
    next_s = s;

    // Base clock at 16x the bit rate as a one-cycle enable
    if (s.divCnt >= CLK_PER_BASE - 16'h0001)
    begin
      next_s.divCnt = '0;
      tick = 1'b1;
    end
    else
      next_s.divCnt = s.divCnt + 16'h0001;

    rxIn = ch3PinsOn ? rxPin : 1'b1;
    halt = s.err.overrun || s.err.framing;
    anyErr = s.err.overrun || s.err.framing || s.err.parity;
    lastBit = frameCfg.sevenBit ? serial_port_pkg::LAST_BIT_SEVEN : serial_port_pkg::LAST_BIT_EIGHT;

    // Transmitter
    bitEnd = tick && (s.txTick == serial_port_pkg::LAST_TICK);
    if (tick && s.txState != serial_port_pkg::TX_IDLE)
      next_s.txTick = s.txTick + 4'h1;
    if (!txEnable)
    begin
      // Aborts any frame; pin already falls back to the port bit
      next_s.txState = serial_port_pkg::TX_IDLE;
      next_s.txTick = '0;
      next_s.txLine = 1'b1;
      next_s.txStop2 = 1'b0;
    end
    else
    begin
      case (s.txState)
        serial_port_pkg::TX_IDLE:
        begin
          next_s.txLine = 1'b1;
          if (!s.txEmpty && !(frameCfg.sync && anyErr))
          begin
            next_s.txShift = s.txHolding;
            next_s.txEmpty = 1'b1;
            next_s.txEnd = 1'b0;
            next_s.txParity = parityOf(s.txHolding, frameCfg.sevenBit, frameCfg.parityOdd);
            next_s.txTick = '0;
            next_s.txBit = '0;
            next_s.txState = frameCfg.sync ? serial_port_pkg::TX_DATA : serial_port_pkg::TX_START;
            next_s.txLine = frameCfg.sync ? s.txHolding[0] : 1'b0;
          end
          else if (s.txEmpty)
            next_s.txEnd = 1'b1;
        end
        serial_port_pkg::TX_START:
          if (bitEnd)
          begin
            next_s.txState = serial_port_pkg::TX_DATA;
            next_s.txLine = s.txShift[0];
          end
        serial_port_pkg::TX_DATA:
          if (bitEnd)
          begin
            if (s.txBit == lastBit)
            begin
              if (frameCfg.sync)
              begin
                next_s.txState = serial_port_pkg::TX_IDLE;
                next_s.txLine = 1'b1;
              end
              else if (frameCfg.parityEnable)
              begin
                next_s.txState = serial_port_pkg::TX_PARITY;
                next_s.txLine = s.txParity;
              end
              else
              begin
                next_s.txState = serial_port_pkg::TX_STOP;
                next_s.txLine = 1'b1;
                next_s.txStop2 = frameCfg.twoStop;
              end
            end
            else
            begin
              // Least significant bit first
              next_s.txShift = {1'b0, s.txShift[7:1]};
              next_s.txLine = s.txShift[1];
              next_s.txBit = s.txBit + 3'h1;
            end
          end
        serial_port_pkg::TX_PARITY:
          if (bitEnd)
          begin
            next_s.txState = serial_port_pkg::TX_STOP;
            next_s.txLine = 1'b1;
            next_s.txStop2 = frameCfg.twoStop;
          end
        serial_port_pkg::TX_STOP:
          if (bitEnd)
          begin
            if (s.txStop2)
              next_s.txStop2 = 1'b0;
            else
              next_s.txState = serial_port_pkg::TX_IDLE;
          end
        default:
          next_s.txState = serial_port_pkg::TX_IDLE;
      endcase
    end
    // A fresh byte is pending even if a transfer happened this cycle
    if (txWrite)
    begin
      next_s.txHolding = txData;
      next_s.txEmpty = 1'b0;
    end

    // Receiver
    sample = tick && (s.rxTick == serial_port_pkg::SAMPLE_TICK);
    bitEnd = tick && (s.rxTick == serial_port_pkg::LAST_TICK);
    if (tick && s.rxState != serial_port_pkg::RX_IDLE)
      next_s.rxTick = s.rxTick + 4'h1;
    if (!rxEnable)
    begin
      // Error flags keep their value; only the frame in progress is dropped
      next_s.rxState = serial_port_pkg::RX_IDLE;
      next_s.rxTick = '0;
    end
    else if (frameCfg.sync)
    begin
      next_s.rxState = serial_port_pkg::RX_IDLE;
      // Sampled on the rising edge of the clock we send out
      if (!halt && s.txState == serial_port_pkg::TX_DATA && tick && s.txTick == serial_port_pkg::SAMPLE_TICK)
      begin
        next_s.rxShift = {rxIn, s.rxShift[7:1]};
        next_s.rxBit = (s.txBit == lastBit) ? 3'h0 : s.txBit + 3'h1;
        if (s.txBit == lastBit)
        begin
          done = 1'b1;
          word = frameCfg.sevenBit ? {1'b0, rxIn, s.rxShift[7:2]} : {rxIn, s.rxShift[7:1]};
        end
      end
    end
    else
    begin
      case (s.rxState)
        serial_port_pkg::RX_IDLE:
          // Low level, not just an edge, so a held break restarts framing
          if (tick && !rxIn && !halt)
          begin
            next_s.rxState = serial_port_pkg::RX_START;
            next_s.rxTick = '0;
            next_s.rxBit = '0;
          end
        serial_port_pkg::RX_START:
          if (sample && rxIn)
            next_s.rxState = serial_port_pkg::RX_IDLE;
          else if (bitEnd)
            next_s.rxState = serial_port_pkg::RX_DATA;
        serial_port_pkg::RX_DATA:
        begin
          if (sample)
            next_s.rxShift = {rxIn, s.rxShift[7:1]};
          if (bitEnd)
          begin
            next_s.rxBit = s.rxBit + 3'h1;
            if (s.rxBit == lastBit)
              next_s.rxState = frameCfg.parityEnable ? serial_port_pkg::RX_PARITY : serial_port_pkg::RX_STOP;
          end
        end
        serial_port_pkg::RX_PARITY:
        begin
          if (sample)
            next_s.rxParity = rxIn;
          if (bitEnd)
            next_s.rxState = serial_port_pkg::RX_STOP;
        end
        serial_port_pkg::RX_STOP:
          if (sample)
          begin
            // Finish at mid stop bit to leave half a bit for the next start
            done = 1'b1;
            word = frameCfg.sevenBit ? {1'b0, s.rxShift[7:1]} : s.rxShift;
            ferr = !rxIn;
            perr = frameCfg.parityEnable && (s.rxParity != parityOf(word, frameCfg.sevenBit, frameCfg.parityOdd));
            next_s.rxState = serial_port_pkg::RX_IDLE;
          end
        default:
          next_s.rxState = serial_port_pkg::RX_IDLE;
      endcase
    end

    // Software clears first so a same-cycle error still lands
    if (errClear.overrun)
      next_s.err.overrun = 1'b0;
    if (errClear.framing)
      next_s.err.framing = 1'b0;
    if (errClear.parity)
      next_s.err.parity = 1'b0;
    // Holding register drains into the buffer, which clears full
    if (s.rxFull && fifoInReady)
      next_s.rxFull = 1'b0;
    if (done)
    begin
      if (next_s.rxFull)
      begin
        // Byte is lost: holding and full untouched
        next_s.err.overrun = 1'b1;
        next_s.err.framing = next_s.err.framing || ferr;
        next_s.err.parity = next_s.err.parity || perr;
      end
      else
      begin
        next_s.rxHolding = word;
        next_s.err.framing = next_s.err.framing || ferr;
        next_s.err.parity = next_s.err.parity || perr;
        if (!ferr && !perr)
          next_s.rxFull = 1'b1;
      end
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s <= '0;
      s.txEmpty <= serial_port_pkg::TX_EMPTY_RESET;
      s.txEnd <= serial_port_pkg::TX_END_RESET;
      s.txLine <= 1'b1;
      s.txState <= serial_port_pkg::TX_IDLE;
      s.rxState <= serial_port_pkg::RX_IDLE;
    end
    else
      s <= next_s;
  end

  // ==========================================================
  // Receive buffer
  // ==========================================================
  // A stalled consumer fills this, then holding stays full and overruns
  rx_byte_fifo #(
    .WIDTH(serial_port_pkg::DATA_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_sys(clk_sys),
    .reset(reset),
    .inValid(s.rxFull),
    .inReady(fifoInReady),
    .inData(s.rxHolding),
    .outValid(rxValid),
    .outReady(rxReady),
    .outData(rxData)
  );

endmodule
`default_nettype wire

// ### dv/serial_port_errors_and_break_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module serial_port_errors_and_break_assertions #(
  parameter logic [15:0] CLK_PER_BASE = 16'h0036,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk_sys, // Clock
  input wire logic reset, // Reset
  input wire serial_port_pkg::frame_cfg_type frameCfg, // Format
  input wire logic txEnable, // Tx on
  input wire logic rxEnable, // Rx on
  input wire logic portDataBit, // Port level
  input wire logic portDirBit, // Port dir
  input wire logic [7:0] portACtrl, // Pin control
  input wire logic txWrite, // Write
  input wire logic [7:0] txData, // Byte
  input wire serial_port_pkg::err_flags_type errClear, // Clears
  input wire logic rxPin, // Rx line
  input wire logic txPinOut, // Tx pin
  input wire logic txPinOe, // Tx drive
  input wire logic sclkOut, // Sync clock
  input wire logic ch3PinsOn, // Pins on
  input wire logic txEmptyFlag, // Empty
  input wire logic txEndFlag, // End
  input wire logic rxFullFlag, // Full
  input wire serial_port_pkg::err_flags_type errFlags, // Errors
  input wire logic rxErrorIrq, // Irq
  input wire logic [7:0] rxHoldingData, // Holding
  input wire logic rxValid, // Valid
  input wire logic rxReady, // Ready
  input wire logic [7:0] rxData // Data
);
  // ==========================================================
  // Properties, all in the system clock domain
  // ==========================================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_irq; rxErrorIrq == (|errFlags); endproperty
  a_irq: assert property (p_irq) else $error("irq not the OR of error flags");
  property p_port; !txEnable |-> txPinOut == portDataBit; endproperty
  a_port: assert property (p_port) else $error("pin not port level when disabled");
  property p_oe; txPinOe == (ch3PinsOn && (txEnable || portDirBit)); endproperty
  a_oe: assert property (p_oe) else $error("pin drive wrong");
  property p_ch3; ch3PinsOn == ((portACtrl & serial_port_pkg::PORT_A_CH3_MASK) == 8'h68); endproperty
  a_ch3: assert property (p_ch3) else $error("pin enable wrong");
  property p_write; txWrite |=> !txEmptyFlag; endproperty
  a_write: assert property (p_write) else $error("write not taken");
  // Load in async mode puts the start bit out on the same edge
  property p_start; $rose(txEmptyFlag) && txEnable && !frameCfg.sync |-> !txPinOut; endproperty
  a_start: assert property (p_start) else $error("no start bit at load");
  property p_fe_clr; $fell(errFlags.framing) |-> $past(errClear.framing); endproperty
  a_fe_clr: assert property (p_fe_clr) else $error("framing flag fell alone");
  property p_ov_clr; $fell(errFlags.overrun) |-> $past(errClear.overrun); endproperty
  a_ov_clr: assert property (p_ov_clr) else $error("overrun flag fell alone");
  property p_pe_clr; $fell(errFlags.parity) |-> $past(errClear.parity); endproperty
  a_pe_clr: assert property (p_pe_clr) else $error("parity flag fell alone");
  property p_over; $rose(errFlags.overrun) |-> rxFullFlag && $stable(rxHoldingData); endproperty
  a_over: assert property (p_over) else $error("overrun touched holding");
  property p_fe_copy; $rose(errFlags.framing) && !errFlags.overrun |-> !rxFullFlag; endproperty
  a_fe_copy: assert property (p_fe_copy) else $error("full set on framing");
  property p_halt; $rose(rxFullFlag) |-> !$past(errFlags.framing) && !$past(errFlags.overrun); endproperty
  a_halt: assert property (p_halt) else $error("received while halted");
  property p_sync; $fell(txEndFlag) |-> !($past(frameCfg.sync) && (|$past(errFlags))); endproperty
  a_sync: assert property (p_sync) else $error("sync send despite errors");
  c_over: cover property ($rose(errFlags.overrun));
  c_abort: cover property ($fell(txEnable) && !txEndFlag);
  c_rx: cover property ($rose(rxValid));
endmodule
`default_nettype wire

// ### dv/serial_peer_model.sv
`timescale 1ns/100ps
`default_nettype none
module serial_peer_model #(
  parameter int BIT_CLKS = 32
) (
  input wire logic clk_sys, // Clock
  input wire logic txLine, // Device tx pin
  output var logic rxLine // Device rx line
);
  logic [7:0] got [$];
  logic [7:0] shift;
  initial rxLine = 1'b1;
  // Frame with chosen stop level, BIT_CLKS clocks a bit
  task automatic sendFrame(input logic [7:0] b, input logic stopLevel);
    @(negedge clk_sys);
    rxLine = 1'b0;
    repeat (BIT_CLKS) @(negedge clk_sys);
    for (int i = 0; i < 8; i++)
    begin
      rxLine = b[i];
      repeat (BIT_CLKS) @(negedge clk_sys);
    end
    rxLine = stopLevel;
    repeat (BIT_CLKS) @(negedge clk_sys);
  endtask
  task automatic setLine(input logic v);
    @(negedge clk_sys);
    rxLine = v;
  endtask
  // Mid-bit capture; a glitch start is dropped like a real receiver would
  initial
  begin
    forever
    begin
      @(negedge txLine);
      repeat (BIT_CLKS / 2) @(posedge clk_sys);
      if (txLine === 1'b0)
      begin
        repeat (8)
        begin
          repeat (BIT_CLKS) @(posedge clk_sys);
          shift = {txLine, shift[7:1]};
        end
        got.push_back(shift);
      end
    end
  end
endmodule
`default_nettype wire

// ### dv/serial_port_errors_and_break_tb.sv
`timescale 1ns/100ps
`default_nettype none
module serial_port_errors_and_break_tb;
  localparam int BIT = 32;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  serial_port_pkg::frame_cfg_type frameCfg = '0;
  serial_port_pkg::err_flags_type errClear = '0;
  serial_port_pkg::err_flags_type errFlags;
  logic txEnable = 1'b1, rxEnable = 1'b1, portDataBit = 1'b1, portDirBit = 1'b1, txWrite = 1'b0, rxReady = 1'b0;
  logic [7:0] portACtrl = 8'h68, txData = 8'h00, rxHoldingData, rxData;
  logic rxPin, txPinOut, txPinOe, sclkOut, ch3PinsOn, txEmptyFlag, txEndFlag, rxFullFlag, rxErrorIrq, rxValid;
  logic txWire;
  logic [7:0] pa [6] = '{8'h68, 8'hff, 8'h60, 8'h48, 8'h28, 8'h00};
  int fails = 0, nCompared = 0, cycles = 0, k;
  always #5 clk_sys = ~clk_sys;
  // Pin pulled high when not driven
  assign txWire = txPinOe ? txPinOut : 1'b1;
  serial_port_errors_and_break #(.CLK_PER_BASE(16'h0002), .FIFO_DEPTH(8)) u_dut (.clk_sys(clk_sys),
    .reset(reset), .frameCfg(frameCfg), .txEnable(txEnable), .rxEnable(rxEnable), .portDataBit(portDataBit),
    .portDirBit(portDirBit), .portACtrl(portACtrl), .txWrite(txWrite), .txData(txData), .errClear(errClear),
    .rxPin(rxPin), .txPinOut(txPinOut), .txPinOe(txPinOe), .sclkOut(sclkOut), .ch3PinsOn(ch3PinsOn),
    .txEmptyFlag(txEmptyFlag), .txEndFlag(txEndFlag), .rxFullFlag(rxFullFlag), .errFlags(errFlags),
    .rxErrorIrq(rxErrorIrq), .rxHoldingData(rxHoldingData), .rxValid(rxValid), .rxReady(rxReady), .rxData(rxData));
  serial_peer_model #(.BIT_CLKS(BIT)) u_peer (.clk_sys(clk_sys), .txLine(txWire), .rxLine(rxPin));
  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrapUp;
    $display("compared %0d mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic txWr(input logic [7:0] d);
    @(negedge clk_sys);
    txWrite = 1'b1;
    txData = d;
    @(negedge clk_sys);
    txWrite = 1'b0;
  endtask
  task automatic pop;
    @(negedge clk_sys);
    rxReady = 1'b1;
    @(negedge clk_sys);
    rxReady = 1'b0;
  endtask
  task automatic clr(input serial_port_pkg::err_flags_type m);
    @(negedge clk_sys);
    errClear = m;
    @(negedge clk_sys);
    errClear = '0;
  endtask
  task automatic waitEnd;
    for (k = 0; k < 2000 && txEndFlag !== 1'b1; k++) @(negedge clk_sys);
    chk({7'h00, txEndFlag}, 8'h01);
  endtask
  // Hang guard, well above the expected run length
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fails++;
      wrapUp;
    end
  end
  // ==========================================================
  // Tests
  // ==========================================================
  initial
  begin
    repeat (6) @(negedge clk_sys);
    reset = 1'b0;
    chk({txEmptyFlag, txEndFlag, rxFullFlag, rxValid, 1'b0, errFlags}, 8'hc0);
    $display("test reset done");
    foreach (pa[i])
    begin
      @(negedge clk_sys);
      portACtrl = pa[i];
      #1;
      chk({7'h00, ch3PinsOn}, {7'h00, (pa[i] & 8'h68) == 8'h68});
      chk({7'h00, txPinOe}, {7'h00, (pa[i] & 8'h68) == 8'h68});
    end
    @(negedge clk_sys);
    portACtrl = 8'h68;
    $display("test pins done");
    txWr(8'h3c);
    repeat (3) @(negedge clk_sys);
    chk({7'h00, txEmptyFlag}, 8'h01);
    txWr(8'h11);
    txWr(8'h22);
    chk({7'h00, txEmptyFlag}, 8'h00);
    waitEnd;
    repeat (BIT) @(negedge clk_sys);
    chk(8'(u_peer.got.size()), 8'h02);
    chk(u_peer.got[0], 8'h3c);
    chk(u_peer.got[1], 8'h22);
    u_peer.got.delete();
    $display("test transmit done");
    u_peer.sendFrame(8'h5a, 1'b1);
    chk({7'h00, rxValid}, 8'h01);
    chk(rxData, 8'h5a);
    pop;
    $display("test receive done");
    u_peer.sendFrame(8'hc3, 1'b0);
    u_peer.setLine(1'b1);
    chk({3'h0, rxFullFlag, rxValid, errFlags}, 8'h02);
    chk(rxHoldingData, 8'hc3);
    chk({7'h00, rxErrorIrq}, 8'h01);
    u_peer.sendFrame(8'h77, 1'b1);
    chk({7'h00, rxValid}, 8'h00);
    chk(rxHoldingData, 8'hc3);
    rxEnable = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk({5'h00, errFlags}, 8'h02);
    rxEnable = 1'b1;
    clr(3'b010);
    chk({5'h00, errFlags}, 8'h00);
    u_peer.setLine(1'b0);
    repeat (12 * BIT) @(negedge clk_sys);
    chk({6'h00, errFlags.framing, errFlags.overrun}, 8'h02);
    clr(3'b010);
    chk({7'h00, errFlags.framing}, 8'h00);
    for (k = 0; k < 20 * BIT && errFlags.framing !== 1'b1; k++) @(negedge clk_sys);
    chk({7'h00, errFlags.framing}, 8'h01);
    chk(rxHoldingData, 8'h00);
    u_peer.setLine(1'b1);
    clr(3'b111);
    $display("test errors done");
    for (int i = 0; i < 10; i++) u_peer.sendFrame(8'(8'h80 + i), 1'b1);
    chk({3'h0, rxFullFlag, 1'b0, errFlags}, 8'h11);
    chk(rxHoldingData, 8'h88);
    for (int i = 0; i < 9; i++)
    begin
      chk(rxData, 8'(8'h80 + i));
      pop;
    end
    chk({7'h00, rxValid}, 8'h00);
    clr(3'b001);
    $display("test overrun done");
    txWr(8'hff);
    repeat (3 * BIT) @(negedge clk_sys);
    portDataBit = 1'b0;
    @(negedge clk_sys);
    txEnable = 1'b0;
    @(negedge clk_sys);
    chk({6'h00, txPinOut, txPinOe}, 8'h01);
    portDirBit = 1'b0;
    #1;
    chk({7'h00, txPinOe}, 8'h00);
    @(negedge clk_sys);
    portDirBit = 1'b1;
    portDataBit = 1'b1;
    #1;
    chk({7'h00, txPinOut}, 8'h01);
    repeat (12 * BIT) @(negedge clk_sys);
    u_peer.got.delete();
    txEnable = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk({6'h00, txPinOut, txEndFlag}, 8'h03);
    $display("test break done");
    // Seven bits, odd parity, two stops: peer sees parity in bit 7
    frameCfg = 5'b01111;
    txWr(8'h35);
    @(negedge clk_sys);
    waitEnd;
    chk(u_peer.got[0], 8'hb5);
    frameCfg = '0;
    $display("test format done");
    u_peer.sendFrame(8'h00, 1'b0);
    u_peer.setLine(1'b1);
    frameCfg.sync = 1'b1;
    txWr(8'h55);
    repeat (4 * BIT) @(negedge clk_sys);
    chk({7'h00, txEmptyFlag}, 8'h00);
    clr(3'b010);
    // Load lands one edge after the clear, so end flag only drops then
    @(negedge clk_sys);
    chk({6'h00, sclkOut, txEndFlag}, 8'h00);
    waitEnd;
    chk({7'h00, txEmptyFlag}, 8'h01);
    frameCfg = '0;
    $display("test sync done");
    wrapUp;
  end
endmodule
bind serial_port_errors_and_break serial_port_errors_and_break_assertions #(.CLK_PER_BASE(CLK_PER_BASE),
  .FIFO_DEPTH(FIFO_DEPTH)) u_chk (.clk_sys(clk_sys), .reset(reset), .frameCfg(frameCfg), .txEnable(txEnable),
  .rxEnable(rxEnable), .portDataBit(portDataBit), .portDirBit(portDirBit), .portACtrl(portACtrl),
  .txWrite(txWrite), .txData(txData), .errClear(errClear), .rxPin(rxPin), .txPinOut(txPinOut), .txPinOe(txPinOe),
  .sclkOut(sclkOut), .ch3PinsOn(ch3PinsOn), .txEmptyFlag(txEmptyFlag), .txEndFlag(txEndFlag),
  .rxFullFlag(rxFullFlag), .errFlags(errFlags), .rxErrorIrq(rxErrorIrq), .rxHoldingData(rxHoldingData),
  .rxValid(rxValid), .rxReady(rxReady), .rxData(rxData));
`default_nettype wire
